// >>> arps_consts.vh
// Constants for the automatic restart power sequencer
`ifndef ARPS_CONSTS_VH
`define ARPS_CONSTS_VH

`define CLK_PERIOD_NS      100
`define TICK_PERIOD_NS     1000000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define SURGE_MIN_NS       16670000
`define SURGE_MIN_CYCLES   ((`SURGE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RESTART_DELAY_MS   20'h005dc
`define SUPPLY_TIMEOUT_MS  20'h003e8
`define SEQ_COMPLETE_MS    20'h001c2
`define MS_PER_S           20'h003e8

`define WINDOW_MIN_S       10'h01e
`define WINDOW_MAX_S       10'h258
`define WINDOW_RST_S       10'h258

`define REG_CTRL           4'h0
`define REG_WINDOW         4'h4
`define REG_STATUS         4'h8
`define REG_REMAIN         4'hc

`define CTRL_ALT_OPT_BIT   0
`define CTRL_POWER_ON_BIT  1
`define CTRL_RST           1'h0

`define RESTART_VECTOR     8'h80
`define LINE_FREQ_VECTOR   8'h9a

`endif

// >>> ms_timer.v
// Reloadable down counter stepped by a shared timebase tick
`timescale 1ns/1ps
`default_nettype none
module ms_timer #(
    parameter W = 20
) (
    input  wire         ref_clk,
    input  wire         srst,
    input  wire         ce,
    input  wire         load,
    input  wire [W-1:0] load_val,
    input  wire         tick,
    output reg  [W-1:0] count_q
);
    always @(posedge ref_clk) begin
        if (srst) begin
            count_q <= {W{1'b0}};
        end else if (ce) begin
            if (load) begin
                count_q <= load_val;
            end else if (tick && count_q != {W{1'b0}}) begin
                count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// >>> surge_stage.v
// One surge limiter stage: minimum feed time, then switch on a peak
`timescale 1ns/1ps
`default_nettype none
module surge_stage #(
    parameter MIN_CYCLES = 166700
) (
    input  wire ref_clk,
    input  wire srst,
    input  wire ce,
    input  wire enable,
    input  wire feed_on,
    input  wire peak,
    output reg  switch_on_q
);
    reg [17:0] count_q;
    reg        armed_q;

    always @(posedge ref_clk) begin
        if (srst) begin
            count_q     <= 18'h00000;
            armed_q     <= 1'b0;
            switch_on_q <= 1'b0;
        end else if (ce) begin
            if (!enable || !feed_on) begin
                // Gate removed; triac opens at its next current zero
                count_q     <= 18'h00000;
                armed_q     <= 1'b0;
                switch_on_q <= 1'b0;
            end else begin
                if (!armed_q) begin
                    if (count_q == MIN_CYCLES[17:0] - 18'h00001) begin
                        armed_q <= 1'b1;
                    end else begin
                        count_q <= count_q + 18'h00001;
                    end
                end
                if (armed_q && peak) begin
                    switch_on_q <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> auto_restart_power_sequencer.v
// Automatic restart sequencer, surge limiter control, line timer source
`timescale 1ns/1ps
`default_nettype none
`include "arps_consts.vh"
module auto_restart_power_sequencer #(
    parameter TICK_CYCLES      = `TICK_CYCLES,
    parameter SURGE_MIN_CYCLES = `SURGE_MIN_CYCLES
) (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        ce,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        mains_present,
    input  wire        off_button_pressed,
    input  wire        thermostats_closed,
    input  wire        auto_mode,
    input  wire        bus_level_monitor,
    input  wire        peak_a,
    input  wire        peak_b,
    input  wire        peak_c,
    input  wire        line_phase_p,
    input  wire        line_phase_n,
    input  wire        alt_line_signal,
    input  wire        alt_source_present,
    output reg         main_power_latch,
    output reg         supply_ac_contactor,
    output reg         supply_good_latch,
    output reg         sequenced_ac_contactor,
    output reg         supply_good_timeout_trip,
    output reg         sequence_complete,
    output reg         hw_initialize,
    output reg         surge_enable_a,
    output reg         surge_enable_b,
    output reg         surge_enable_c,
    output wire        surge_switch_a,
    output wire        surge_switch_b,
    output wire        surge_switch_c,
    output reg         alt_source_fail_relay,
    output reg         alt_source_selected,
    output reg         program_interrupt,
    output reg  [7:0]  program_interrupt_vector
);
    localparam [2:0] ST_OFF   = 3'h0;
    localparam [2:0] ST_SUPW  = 3'h1;
    localparam [2:0] ST_SEQ   = 3'h2;
    localparam [2:0] ST_RUN   = 3'h3;
    localparam [2:0] ST_TRIP  = 3'h4;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [13:0] tick_cnt_q;
    reg         tick_q;
    reg         mains_q;
    reg         alt_opt_q;
    reg         power_on_q;
    reg  [9:0]  window_s_q;
    reg         auto_start_q;
    reg         restart_pend_q;
    reg         line_pend_q;
    reg         line_sig_q;
    reg         line_sig_d;

    wire [19:0] win_cnt;
    wire [19:0] dly_cnt;
    wire [19:0] sgt_cnt;
    wire [19:0] seq_cnt;
    wire [19:0] win_full;
    wire        window_open;
    wire        shutdown;
    wire        mains_return;
    wire        seq_on;
    wire        win_load;
    wire [19:0] win_val;
    wire        alt_use;
    wire        line_event;
    wire        delay_done;
    wire        can_start;

    always @(posedge ref_clk) begin
        if (srst) begin
            tick_cnt_q <= 14'h0000;
            tick_q     <= 1'b0;
        end else if (ce) begin
            tick_q <= 1'b0;
            if (tick_cnt_q == TICK_CYCLES[13:0] - 14'h0001) begin
                tick_cnt_q <= 14'h0000;
                tick_q     <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 14'h0001;
            end
        end
    end

    assign seq_on       = (state_q == ST_SEQ) || (state_q == ST_RUN);
    assign shutdown     = seq_on && (state_d == ST_OFF);
    assign mains_return = mains_present && !mains_q;
    assign win_full     = {10'h000, window_s_q} * `MS_PER_S;
    assign window_open  = (win_cnt != 20'h00000);
    // Window held closed while sequenced AC is on
    assign win_load     = shutdown || seq_on ||
                          (mains_return && !seq_on);
    assign win_val      = (seq_on && !shutdown) ? 20'h00000 : win_full;
    assign delay_done   = (dly_cnt == 20'h00000) && mains_present;
    assign can_start    = !off_button_pressed && thermostats_closed &&
                          mains_present;

    ms_timer #(.W(20)) u_window (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .ce       (ce),
        .load     (win_load),
        .load_val (win_val),
        .tick     (tick_q),
        .count_q  (win_cnt)
    );

    // Reloaded outside idle and while mains is absent
    ms_timer #(.W(20)) u_delay (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .ce       (ce),
        .load     ((state_q != ST_OFF) || !mains_present),
        .load_val (`RESTART_DELAY_MS),
        .tick     (tick_q),
        .count_q  (dly_cnt)
    );

    ms_timer #(.W(20)) u_timeout (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .ce       (ce),
        .load     (state_q != ST_SUPW),
        .load_val (`SUPPLY_TIMEOUT_MS),
        .tick     (tick_q),
        .count_q  (sgt_cnt)
    );

    ms_timer #(.W(20)) u_seq (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .ce       (ce),
        .load     (state_q != ST_SEQ),
        .load_val (`SEQ_COMPLETE_MS),
        .tick     (tick_q),
        .count_q  (seq_cnt)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (can_start && power_on_q) begin
                    state_d = ST_SUPW;
                end else if (can_start && delay_done && window_open &&
                             auto_mode) begin
                    state_d = ST_SUPW;
                end
            end
            ST_SUPW: begin
                if (!can_start) begin
                    state_d = ST_OFF;
                end else if (bus_level_monitor) begin
                    state_d = ST_SEQ;
                end else if (sgt_cnt == 20'h00000) begin
                    state_d = ST_TRIP;
                end
            end
            ST_SEQ: begin
                if (!can_start || !bus_level_monitor) begin
                    state_d = ST_OFF;
                end else if (seq_cnt == 20'h00000) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!can_start || !bus_level_monitor) begin
                    state_d = ST_OFF;
                end
            end
            ST_TRIP: begin
                if (!mains_present || !auto_mode || !window_open) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            state_q                  <= ST_OFF;
            mains_q                  <= 1'b1;
            auto_start_q             <= 1'b0;
            main_power_latch         <= 1'b0;
            supply_ac_contactor      <= 1'b0;
            supply_good_latch        <= 1'b0;
            sequenced_ac_contactor   <= 1'b0;
            supply_good_timeout_trip <= 1'b0;
            sequence_complete        <= 1'b0;
            hw_initialize            <= 1'b1;
            surge_enable_a           <= 1'b0;
            surge_enable_b           <= 1'b0;
            surge_enable_c           <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            mains_q <= mains_present;
            if (state_q == ST_OFF && state_d == ST_SUPW) begin
                auto_start_q <= !power_on_q;
            end
            main_power_latch         <= (state_d != ST_OFF);
            supply_ac_contactor      <= (state_d == ST_SUPW) ||
                                        (state_d == ST_SEQ) ||
                                        (state_d == ST_RUN);
            supply_good_latch        <= (state_d == ST_SEQ) ||
                                        (state_d == ST_RUN);
            sequenced_ac_contactor   <= (state_d == ST_SEQ) ||
                                        (state_d == ST_RUN);
            supply_good_timeout_trip <= (state_d == ST_TRIP);
            sequence_complete        <= (state_d == ST_RUN);
            hw_initialize            <= (state_d != ST_RUN);
            surge_enable_a           <= (state_d != ST_OFF);
            surge_enable_b           <= (state_d != ST_OFF);
            surge_enable_c           <= (state_d != ST_OFF);
        end
    end

    surge_stage #(.MIN_CYCLES(SURGE_MIN_CYCLES)) u_stage_a (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .ce          (ce),
        .enable      (surge_enable_a),
        .feed_on     (supply_ac_contactor),
        .peak        (peak_a),
        .switch_on_q (surge_switch_a)
    );

    surge_stage #(.MIN_CYCLES(SURGE_MIN_CYCLES)) u_stage_b (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .ce          (ce),
        .enable      (surge_enable_b),
        .feed_on     (supply_ac_contactor),
        .peak        (peak_b),
        .switch_on_q (surge_switch_b)
    );

    // Peripheral and analog stage fed from sequenced AC, so it lags
    surge_stage #(.MIN_CYCLES(SURGE_MIN_CYCLES)) u_stage_c (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .ce          (ce),
        .enable      (surge_enable_c),
        .feed_on     (sequenced_ac_contactor),
        .peak        (peak_c),
        .switch_on_q (surge_switch_c)
    );

    // Line-frequency source selection and events
    assign alt_use = alt_opt_q && sequenced_ac_contactor &&
                     alt_source_present;
    always @* begin
        if (alt_use) begin
            line_sig_d = alt_line_signal;
        end else begin
            line_sig_d = line_phase_p ^ line_phase_n;
        end
    end
    assign line_event = sequenced_ac_contactor && line_sig_d && !line_sig_q;

    always @(posedge ref_clk) begin
        if (srst) begin
            line_sig_q              <= 1'b0;
            restart_pend_q          <= 1'b0;
            line_pend_q             <= 1'b0;
            alt_source_fail_relay   <= 1'b0;
            alt_source_selected     <= 1'b0;
            program_interrupt       <= 1'b0;
            program_interrupt_vector <= 8'h00;
        end else if (ce) begin
            line_sig_q            <= line_sig_d;
            alt_source_selected   <= alt_use;
            alt_source_fail_relay <= alt_opt_q && sequenced_ac_contactor &&
                                     !alt_source_present;
            program_interrupt     <= 1'b0;
            if (restart_pend_q) begin
                // Restart interrupt outranks line-frequency events
                program_interrupt        <= 1'b1;
                program_interrupt_vector <= `RESTART_VECTOR;
                restart_pend_q           <= 1'b0;
                line_pend_q              <= line_pend_q || line_event;
            end else if (line_pend_q) begin
                program_interrupt        <= 1'b1;
                program_interrupt_vector <= `LINE_FREQ_VECTOR;
                line_pend_q              <= line_event;
            end else begin
                line_pend_q <= line_event;
            end
            if (state_q == ST_SEQ && state_d == ST_RUN && auto_start_q) begin
                restart_pend_q <= 1'b1;
            end
        end
    end

    // Avalon-MM slave: one wait cycle, then the access completes
    always @(posedge ref_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            alt_opt_q       <= `CTRL_RST;
            power_on_q      <= 1'b0;
            window_s_q      <= `WINDOW_RST_S;
        end else if (ce) begin
            if (state_q != ST_OFF) begin
                power_on_q <= 1'b0;
            end
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    `REG_CTRL:   avs_readdata <= {30'h0, power_on_q,
                                                  alt_opt_q};
                    `REG_WINDOW: avs_readdata <= {22'h0, window_s_q};
                    `REG_STATUS: avs_readdata <= {16'h0,
                        alt_source_selected, alt_source_fail_relay,
                        window_open, hw_initialize, sequence_complete,
                        supply_good_timeout_trip, sequenced_ac_contactor,
                        supply_good_latch, supply_ac_contactor,
                        main_power_latch, surge_switch_c, surge_switch_b,
                        surge_switch_a, state_q};
                    `REG_REMAIN: avs_readdata <= {12'h0, win_cnt};
                    default:     avs_readdata <= 32'h00000000;
                endcase
            end else begin
                avs_waitrequest <= 1'b1;
                if (avs_write && !avs_waitrequest) begin
                    if (avs_address == `REG_CTRL) begin
                        alt_opt_q  <= avs_writedata[`CTRL_ALT_OPT_BIT];
                        power_on_q <= avs_writedata[`CTRL_POWER_ON_BIT];
                    end
                    if (avs_address == `REG_WINDOW) begin
                        if (avs_writedata[9:0] < `WINDOW_MIN_S) begin
                            window_s_q <= `WINDOW_MIN_S;
                        end else if (avs_writedata[31:10] != 22'h0 ||
                                     avs_writedata[9:0] > `WINDOW_MAX_S) begin
                            window_s_q <= `WINDOW_MAX_S;
                        end else begin
                            window_s_q <= avs_writedata[9:0];
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> arps_monitor.sv
// Port checks for the restart sequencer
`timescale 1ns/1ps
`default_nettype none
`include "arps_consts.vh"
module arps_monitor #(
    parameter SURGE_MIN_CYCLES = 20
) (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       main_power_latch,
    input wire logic       supply_ac_contactor,
    input wire logic       sequenced_ac_contactor,
    input wire logic       supply_good_timeout_trip,
    input wire logic       sequence_complete,
    input wire logic       hw_initialize,
    input wire logic       surge_enable_a,
    input wire logic       surge_enable_b,
    input wire logic       surge_enable_c,
    input wire logic       surge_switch_a,
    input wire logic       surge_switch_b,
    input wire logic       surge_switch_c,
    input wire logic       peak_a,
    input wire logic       line_phase_p,
    input wire logic       line_phase_n,
    input wire logic       alt_source_selected,
    input wire logic       alt_source_fail_relay,
    input wire logic       program_interrupt,
    input wire logic [7:0] program_interrupt_vector
);
    int cnt_a;
    int cnt_c;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // Cycles enabled and fed
    always @(posedge ref_clk) begin
        cnt_a <= (surge_enable_a && supply_ac_contactor) ? cnt_a + 1 : 0;
        cnt_c <= (surge_enable_c && sequenced_ac_contactor) ? cnt_c + 1 : 0;
    end
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("not one wait cycle");
    AST_SURGE_ON: assert property ($rose(main_power_latch) |-> ##[0:1]
        (surge_enable_a && surge_enable_b && surge_enable_c))
        else $error("enables missing");
    AST_SURGE_OFF: assert property ($fell(main_power_latch) |-> ##[0:1]
        !(surge_enable_a || surge_enable_b || surge_enable_c))
        else $error("enables left on");
    AST_SURGE_A: assert property ($rose(surge_switch_a) |->
        cnt_a >= SURGE_MIN_CYCLES && $past(peak_a))
        else $error("stage a early or off peak");
    AST_SURGE_C: assert property ($rose(surge_switch_c) |->
        cnt_c >= SURGE_MIN_CYCLES && surge_switch_a && surge_switch_b)
        else $error("stage c early or out of order");
    AST_RESTART_IRQ: assert property (program_interrupt &&
        program_interrupt_vector == `RESTART_VECTOR
        |-> !hw_initialize && sequence_complete)
        else $error("restart interrupt in initialize");
    AST_INIT_REL: assert property ($fell(hw_initialize)
        |-> sequence_complete)
        else $error("initialize released early");
    AST_TRIP_HOLD: assert property ($rose(supply_good_timeout_trip)
        |=> (supply_good_timeout_trip && main_power_latch
        && !supply_ac_contactor)[*8])
        else $error("trip not held");
    AST_LINE_IRQ: assert property ($rose(line_phase_p ^ line_phase_n)
        && sequenced_ac_contactor && !alt_source_selected |-> ##[1:4]
        (program_interrupt && program_interrupt_vector == `LINE_FREQ_VECTOR))
        else $error("no line interrupt");
    AST_ALT_FAIL: assert property (alt_source_selected
        |-> !alt_source_fail_relay)
        else $error("alternate selected in alarm");
endmodule
bind auto_restart_power_sequencer arps_monitor #(
    .SURGE_MIN_CYCLES(SURGE_MIN_CYCLES)
) u_arps_monitor (.*);
`default_nettype wire

// >>> au_interrupt_model.sv
// Processor side: takes interrupts only once initialize is released
`timescale 1ns/1ps
`default_nettype none
module au_interrupt_model (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       program_interrupt,
    input  wire logic [7:0] program_interrupt_vector,
    input  wire logic       hw_initialize,
    output var  logic       taken,
    output var  logic [7:0] taken_vec
);
    // Requests during initialize are lost
    always @(posedge ref_clk) begin
        taken <= !srst && program_interrupt && !hw_initialize;
        taken_vec <= program_interrupt_vector;
    end
endmodule
`default_nettype wire

// >>> tb_auto_restart_power_sequencer.sv
// Bench for the automatic restart power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "arps_consts.vh"
module tb_auto_restart_power_sequencer;
    logic        ref_clk, srst, ce, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        mains_present, off_button_pressed, thermostats_closed;
    logic        auto_mode, bus_level_monitor, peak_a, peak_b, peak_c;
    logic        line_phase_p, line_phase_n, alt_line_signal;
    logic        alt_source_present, main_power_latch, supply_ac_contactor;
    logic        supply_good_latch, sequenced_ac_contactor, hw_initialize;
    logic        supply_good_timeout_trip, sequence_complete, taken;
    logic        surge_enable_a, surge_enable_b, surge_enable_c;
    logic        surge_switch_a, surge_switch_b, surge_switch_c;
    logic        alt_source_fail_relay, alt_source_selected, program_interrupt;
    logic [7:0]  program_interrupt_vector, taken_vec;
    logic [31:0] rd_q[$];
    logic [7:0]  irq_q[$];
    int          err_count, tests_run, pk_cnt, pk_per;
    integer      seed;
    logic [31:0] wval;

    auto_restart_power_sequencer #(.TICK_CYCLES(10), .SURGE_MIN_CYCLES(20))
        u_auto_restart_power_sequencer (.*);
    au_interrupt_model u_au_interrupt_model (.*);

    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    // Peaks at a random spacing
    always @(posedge ref_clk) begin
        pk_cnt <= (pk_cnt >= pk_per) ? 0 : pk_cnt + 1;
        {peak_a, peak_b, peak_c} <= {3{pk_cnt == 0}};
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        {avs_write, avs_read} <= {wr, !wr};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        chk("bus answer", avs_waitrequest, 32'h0);
        {avs_write, avs_read} <= 2'h0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic wait_lv(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    // Toggle a timer input twice: 0 p, 1 n, 2 alt
    task automatic edge_on(input int sel, input logic hit);
        if (hit)
            irq_q.push_back(`LINE_FREQ_VECTOR);
        repeat (2) begin
            @(posedge ref_clk);
            case (sel)
                0: line_phase_p <= !line_phase_p;
                1: line_phase_n <= !line_phase_n;
                default: alt_line_signal <= !alt_line_signal;
            endcase
            repeat (8) @(posedge ref_clk);
        end
    endtask

    // Oldest note against each result
    always @(posedge ref_clk) begin
        if (taken === 1'b1) begin
            if (irq_q.size() == 0)
                chk("spare interrupt", taken_vec, 32'h0);
            else
                chk("vector", taken_vec, irq_q.pop_front());
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk("readdata", avs_readdata, rd_q.pop_front());
    end

    initial begin
        repeat (95000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end

    initial begin
        seed = 32'h8a1d0ec1;
        pk_per = 5 + ($unsigned($random(seed)) % 6);
        wval = 30 + ($unsigned($random(seed)) % 571);
        pk_cnt = 0;
        {srst, ce, avs_read, avs_write, avs_address} = 8'hc0;
        avs_writedata = 32'h0;
        {mains_present, off_button_pressed, thermostats_closed} = 3'h5;
        {auto_mode, bus_level_monitor, line_phase_p, line_phase_n} = 4'h0;
        {alt_line_signal, alt_source_present} = 2'h0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        chk("idle wait", avs_waitrequest, 32'h1);
        chk("init held", hw_initialize, 32'h1);
        rd(`REG_WINDOW, {22'h0, `WINDOW_RST_S});
        rd(4'h2, 32'h0);
        wr(`REG_WINDOW, 32'h3ff);
        rd(`REG_WINDOW, {22'h0, `WINDOW_MAX_S});
        wr(`REG_WINDOW, 32'h5);
        rd(`REG_WINDOW, {22'h0, `WINDOW_MIN_S});
        wr(`REG_WINDOW, wval);
        rd(`REG_WINDOW, wval);
        wr(`REG_CTRL, 32'h2);
        wait_lv(main_power_latch, 1'b1, 50);
        repeat (2) @(posedge ref_clk);
        chk("enables", {surge_enable_a, surge_enable_b, surge_enable_c}, 32'h7);
        bus_level_monitor <= 1'b1;
        wait_lv(sequence_complete, 1'b1, 6000);
        @(posedge ref_clk);
        chk("init off", hw_initialize, 32'h0);
        chk("switches", {surge_switch_a, surge_switch_b, surge_switch_c}, 32'h7);
        edge_on(0, 1'b1);
        edge_on(1, 1'b1);
        wr(`REG_CTRL, 32'h1);
        repeat (4) @(posedge ref_clk);
        chk("alt", {alt_source_fail_relay, alt_source_selected}, 32'h2);
        edge_on(0, 1'b1);
        alt_source_present <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("alt", {alt_source_fail_relay, alt_source_selected}, 32'h1);
        edge_on(2, 1'b1);
        edge_on(0, 1'b0);
        alt_source_present <= 1'b0;
        repeat (4) @(posedge ref_clk);
        edge_on(1, 1'b1);
        wr(`REG_CTRL, 32'h0);
        auto_mode <= 1'b1;
        mains_present <= 1'b0;
        bus_level_monitor <= 1'b0;
        repeat (300) @(posedge ref_clk);
        chk("off", {main_power_latch, surge_enable_a, surge_enable_b, surge_enable_c}, 32'h0);
        chk("init held", hw_initialize, 32'h1);
        for (int i = 0; i < 2; i++) begin
            mains_present <= 1'b1;
            repeat (14800) @(posedge ref_clk);
            chk("latch early", main_power_latch, 32'h0);
            wait_lv(main_power_latch, 1'b1, 400);
            chk("latch", main_power_latch, 32'h1);
            if (i == 0) begin
                mains_present <= 1'b0;
                repeat (20) @(posedge ref_clk);
                chk("latch lost", main_power_latch, 32'h0);
            end
        end
        irq_q.push_back(`RESTART_VECTOR);
        bus_level_monitor <= 1'b1;
        wait_lv(sequence_complete, 1'b1, 6000);
        repeat (10) @(posedge ref_clk);
        chk("restart irq", irq_q.size(), 32'h0);
        off_button_pressed <= 1'b1;
        bus_level_monitor <= 1'b0;
        repeat (16000) @(posedge ref_clk);
        chk("latch off", main_power_latch, 32'h0);
        off_button_pressed <= 1'b0;
        thermostats_closed <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk("latch hot", main_power_latch, 32'h0);
        thermostats_closed <= 1'b1;
        wait_lv(main_power_latch, 1'b1, 50);
        repeat (9900) @(posedge ref_clk);
        chk("trip early", supply_good_timeout_trip, 32'h0);
        wait_lv(supply_good_timeout_trip, 1'b1, 300);
        repeat (2000) @(posedge ref_clk);
        chk("trip", {supply_good_timeout_trip, main_power_latch, supply_ac_contactor}, 32'h6);
        auto_mode <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk("manual", {supply_good_timeout_trip, main_power_latch}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
